/* File: verilog/mrp_phy_end.sv */
// Purpose: transceiver end of the MII/RMII/reverse-MII link
// Assumes: line side offers one nibble per symbol period
// Notes:   pin clocks are scaled by HALF_MII and HALF_RMII
`timescale 1ns/100ps
module mrp_phy_end
#(
   parameter int HALF_MII  = mrp_pkg::MRP_HALF_MII,  // mii half period
   parameter int HALF_RMII = mrp_pkg::MRP_HALF_RMII  // rmii half period
)
(
   input  wire logic       clk_sys,            // system clock 25 MHz
   input  wire logic       reset_n,            // async reset, low active
   input  wire logic       battery_supply_ok,  // battery above por level
   input  wire logic       test_mode,          // test or jitter test
   input  wire logic [1:0] mode_strap,         // variant strap pins
   input  wire logic       line_rx_valid,      // line nibble is data
   input  wire logic [3:0] line_rx_data,       // line nibble
   input  wire logic       line_rx_err,        // line nibble has errors
   input  wire logic       line_false_carrier, // line saw false carrier
   output logic            line_rx_take,       // line nibble used, pulse
   output logic            line_tx_valid,      // nibble to line, pulse
   output logic      [3:0] line_tx_data,       // nibble to line
   output logic            line_tx_err,        // error propagation
   output logic            line_tx_rsvd,       // reserved code seen
   output logic            phy_enabled,        // interface active
   mrp_link_if.phy         lnk                 // link pins
);
   import mrp_pkg::*;

   typedef struct packed {
      logic [1:0]          boot;
      logic                cfg_done;
      mrp_mode_t           mode;
      logic [3:0]          s_mode;
      logic [MRP_DIV_W-1:0] div;
      logic                own_clk;
      logic [1:0]          s_txc;
      logic [1:0]          s_rxc;
      logic [1:0]          s_ref;
      logic [1:0]          s_en;
      logic [11:0]         s_tx;
      logic                tlast;
      logic                rlast;
      logic [3:0]          rxd;
      logic                rx_dv;
      logic                rx_er;
      logic                rx_oe;
      logic                half_r;
      logic [1:0]          hi_r;
      logic                half_t;
      logic [1:0]          lo_t;
      logic                take;
      logic                tv;
      logic [3:0]          td;
      logic                te;
      logic                tr;
      logic                run;
      logic                txc_oe;
      logic                rxc_oe;
      logic                ref_oe;
      logic                tst_oe;
   } mrp_phy_st_t;

   mrp_phy_st_t          q;
   mrp_phy_st_t          n;
   logic                 rst_n_int;
   logic                 tclk;
   logic                 rclk;
   logic                 rmii;
   logic                 run;
   logic [MRP_DIV_W-1:0] half;
   logic [5:0]           ts;

   ////////////////////////////////////////////////////////////////////////
   // power-off: low battery acts as reset, all outputs released
   assign rst_n_int = reset_n & battery_supply_ok;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      n = q;
      n.take = 1'b0;
      n.tv = 1'b0;
      n.tr = 1'b0;
      n.s_mode = {q.s_mode[1:0], mode_strap};
      n.s_txc = {q.s_txc[0], lnk.txc};
      n.s_rxc = {q.s_rxc[0], lnk.rxc};
      n.s_ref = {q.s_ref[0], lnk.ref_clock_input};
      n.s_en = {q.s_en[0], lnk.en_pin};
      n.s_tx = {q.s_tx[5:0], lnk.tx_en, lnk.tx_er, lnk.txd};
      ts = q.s_tx[11:6];
      // straps are taken once after release and then held
      if (!q.cfg_done)
      begin
         if (q.boot == MRP_CFG_WAIT)
         begin
            n.cfg_done = 1'b1;
            n.mode = mrp_mode_t'(q.s_mode[3:2]);
         end
         else
            n.boot = q.boot + 2'h1;
      end
      // own pin clock from the system clock
      rmii = (q.mode == MRP_RMII) || (q.mode == MRP_RMII_EXT);
      half = rmii ? MRP_DIV_W'(HALF_RMII) : MRP_DIV_W'(HALF_MII);
      if (q.div >= half - MRP_DIV_W'(1))
      begin
         n.div = '0;
         n.own_clk = ~q.own_clk;
      end
      else
         n.div = q.div + MRP_DIV_W'(1);
      // choose the clock that times each direction
      case (q.mode)
         MRP_MII:      begin tclk = q.own_clk;  rclk = q.own_clk;  end
         MRP_RMII:     begin tclk = q.own_clk;  rclk = q.own_clk;  end
         MRP_RMII_EXT: begin tclk = q.s_ref[1]; rclk = q.s_ref[1]; end
         MRP_REV:      begin tclk = q.s_txc[1]; rclk = q.s_rxc[1]; end
         default:      begin tclk = 1'b0;       rclk = 1'b0;       end
      endcase
      n.tlast = tclk;
      n.rlast = rclk;
      // enable pin is held high internally while it carries test clock
      run = q.cfg_done && (test_mode || q.s_en[1]);
      n.run = run;
      n.tst_oe = q.cfg_done && test_mode;
      n.txc_oe = run && (q.mode == MRP_MII);
      n.rxc_oe = run && (q.mode == MRP_MII);
      n.ref_oe = run && (q.mode == MRP_RMII);
      n.rx_oe = run;
      // receive path: launch on the falling edge
      if (!run)
      begin
         n.rx_dv = 1'b0;
         n.rx_er = 1'b0;
         n.rxd = MRP_NIB_IDLE;
         n.half_r = 1'b0;
         n.half_t = 1'b0;
      end
      else if (!rclk && q.rlast)
      begin
         if (!rmii)
         begin
            n.take = 1'b1;
            n.rx_dv = line_rx_valid;
            n.rx_er = line_rx_valid ? line_rx_err : line_false_carrier;
            n.rxd = line_rx_valid ? line_rx_data
                  : (line_false_carrier ? MRP_NIB_FALSE : MRP_NIB_IDLE);
         end
         else if (q.half_r)
         begin
            n.rxd = {MRP_DIB_PAD, q.hi_r};
            n.half_r = 1'b0;
         end
         else
         begin
            // no false carrier code exists here; it reads as interframe
            n.take = 1'b1;
            n.rx_dv = line_rx_valid;
            n.rx_er = line_rx_valid & line_rx_err;
            n.rxd = {MRP_DIB_PAD,
                     line_rx_valid ? line_rx_data[1:0] : MRP_DIB_IDLE};
            n.hi_r = line_rx_data[3:2];
            n.half_r = line_rx_valid;
         end
      end
      // transmit path: sample on the rising edge
      if (run && tclk && !q.tlast)
      begin
         if (!rmii)
         begin
            n.tv = ts[5];
            n.te = ts[5] & ts[4];
            n.tr = !ts[5] && ts[4];
            n.td = ts[3:0];
         end
         else if (!ts[5])
            n.half_t = 1'b0;
         else if (!q.half_t)
         begin
            n.lo_t = ts[1:0];
            n.half_t = 1'b1;
         end
         else
         begin
            n.tv = 1'b1;
            n.te = 1'b0;
            n.td = {ts[1:0], q.lo_t};
            n.half_t = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_sys or negedge rst_n_int)
   begin
      if (!rst_n_int)
         q <= '0;
      else
         q <= n;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from state; no col or crs pins exist
   assign line_rx_take        = q.take;
   assign line_tx_valid       = q.tv;
   assign line_tx_data        = q.td;
   assign line_tx_err         = q.te;
   assign line_tx_rsvd        = q.tr;
   assign phy_enabled         = q.run;
   assign lnk.rxd             = q.rxd;
   assign lnk.rx_dv           = q.rx_dv;
   assign lnk.rx_er           = q.rx_er;
   assign lnk.rx_oe           = q.rx_oe;
   assign lnk.txc_phy         = q.own_clk;
   assign lnk.txc_phy_oe      = q.txc_oe;
   assign lnk.rxc_phy         = q.own_clk;
   assign lnk.rxc_phy_oe      = q.rxc_oe;
   assign lnk.ref_clk_phy     = q.own_clk;
   assign lnk.ref_clk_phy_oe  = q.ref_oe;
   assign lnk.test_clk_phy    = q.own_clk;
   assign lnk.test_clk_phy_oe = q.tst_oe;
endmodule : mrp_phy_end

/* File: verilog/mrp_pkg.sv */
// Purpose: shared constants and types for both ends of the MII/RMII link
// Assumes: one system clock at 25 MHz on each end
// Notes:   pin clocks are scaled down so that two-flop sampling can follow
package mrp_pkg;
   // interface variant, taken from the strap pins at power-up
   typedef enum logic [1:0]
   {
      MRP_MII      = 2'b00,
      MRP_RMII     = 2'b01,
      MRP_RMII_EXT = 2'b10,
      MRP_REV      = 2'b11
   } mrp_mode_t;

   // nominal rates in MHz
   localparam int MRP_SYS_CLK_MHZ  = 25;
   localparam int MRP_MII_CLK_MHZ  = 25;
   localparam int MRP_RMII_CLK_MHZ = 50;

   // half periods of the pin clocks in system cycles (scaled)
   localparam int MRP_DIV_W     = 8;
   localparam int MRP_HALF_MII  = 16;
   localparam int MRP_HALF_RMII =
      MRP_HALF_MII * MRP_MII_CLK_MHZ / MRP_RMII_CLK_MHZ;

   // symbol codes
   localparam logic [3:0] MRP_NIB_IDLE  = 4'h0;
   localparam logic [3:0] MRP_NIB_FALSE = 4'hE;
   localparam logic [1:0] MRP_DIB_IDLE  = 2'h0;
   localparam logic [1:0] MRP_DIB_PAD   = 2'h0;

   // cycles after reset release before the straps are taken
   localparam logic [1:0] MRP_CFG_WAIT = 2'h3;
endpackage : mrp_pkg

/* File: verilog/mrp_link_if.sv */
// Purpose: pins between the transceiver end and the controller end
// Assumes: each end gives an output enable for every pin it may drive except ref_clock_input
// Notes:   no collision or carrier sense pins exist on this link
`timescale 1ns/100ps
interface mrp_link_if;
   logic [3:0] txd;            // transmit data, controller to phy
   logic       tx_en_drv;      // transmit enable as driven
   logic       tx_er_drv;      // transmit error as driven
   logic       tx_oe;          // controller drives transmit pins
   logic       tx_en;          // resolved transmit enable
   logic       tx_er;          // resolved transmit error
   logic [3:0] rxd;            // receive data, phy to controller
   logic       rx_dv;          // receive valid, crs_dv in rmii
   logic       rx_er;          // receive error
   logic       rx_oe;          // phy drives receive pins
   logic       txc_phy;        // transmit clock from phy
   logic       txc_phy_oe;     // phy drives transmit clock
   logic       txc_mac;        // transmit clock from peer
   logic       txc_mac_oe;     // peer drives transmit clock
   logic       txc;            // resolved transmit clock
   logic       rxc_phy;        // receive clock from phy
   logic       rxc_phy_oe;     // phy drives receive clock
   logic       rxc_mac;        // receive clock from peer
   logic       rxc_mac_oe;     // peer drives receive clock
   logic       rxc;            // resolved receive clock
   logic       ref_clk_phy;    // rmii reference from phy
   logic       ref_clk_phy_oe; // phy drives reference
   logic       ref_clk;        // resolved reference clock
   logic       ref_clock_input; // external 50 MHz oscillator input
   logic       en_mac;         // enable level from controller
   logic       en_mac_oe;      // controller drives enable pin
   logic       test_clk_phy;   // test_tx_clock_out level
   logic       test_clk_phy_oe; // phy drives enable pin
   logic       en_pin;         // resolved enable pin

   // pull-downs on undriven transmit pins read as no transmission
   assign tx_en = tx_oe ? tx_en_drv : 1'b0;
   assign tx_er = tx_oe ? tx_er_drv : 1'b0;

   // clock pins: the end that enables its driver sets the level, the phy end if both do
   assign txc = txc_phy_oe ? txc_phy : (txc_mac_oe ? txc_mac : 1'b0);
   assign rxc = rxc_phy_oe ? rxc_phy : (rxc_mac_oe ? rxc_mac : 1'b0);
   assign ref_clk = ref_clk_phy_oe ? ref_clk_phy : 1'b0;
   assign en_pin = test_clk_phy_oe ? test_clk_phy
                 : (en_mac_oe ? en_mac : 1'b0);

   modport phy
   (
      input  txd, tx_en, tx_er, txc, rxc, ref_clock_input, en_pin,
      output rxd, rx_dv, rx_er, rx_oe, txc_phy, txc_phy_oe,
      output rxc_phy, rxc_phy_oe, ref_clk_phy, ref_clk_phy_oe,
      output test_clk_phy, test_clk_phy_oe
   );
   modport mac
   (
      input  rxd, rx_dv, rx_er, txc, rxc, ref_clk,
      output txd, tx_en_drv, tx_er_drv, tx_oe, txc_mac, txc_mac_oe,
      output rxc_mac, rxc_mac_oe, ref_clock_input, en_mac, en_mac_oe
   );
endinterface : mrp_link_if

/* File: verilog/mrp_mac_end.sv */
// Purpose: controller end (or peer phy in reverse mode) of the link
// Assumes: same strap setting as the phy end
// Notes:   drives peer clocks in reverse mode and the oscillator in rmii_ext
`timescale 1ns/100ps
module mrp_mac_end
#(
   parameter int HALF_MII  = mrp_pkg::MRP_HALF_MII,  // mii half period
   parameter int HALF_RMII = mrp_pkg::MRP_HALF_RMII  // rmii half period
)
(
   input  wire logic       clk_sys,        // system clock 25 MHz
   input  wire logic       reset_n,        // async reset, low active
   input  wire logic [1:0] mode_strap,     // variant strap pins
   input  wire logic       phy_en,         // level for phy enable pin
   input  wire logic       phy_en_release, // let phy drive enable pin
   input  wire logic       tx_valid,       // nibble offered
   input  wire logic [3:0] tx_data,        // nibble to send
   input  wire logic       tx_err,         // request error propagation
   output logic            tx_take,        // nibble accepted, pulse
   output logic            rx_valid,       // nibble received, pulse
   output logic      [3:0] rx_data,        // received nibble
   output logic            rx_err,         // nibble had errors
   output logic            rx_false,       // false carrier, pulse
   mrp_link_if.mac         lnk             // link pins
);
   import mrp_pkg::*;

   typedef struct packed {
      logic [1:0]          boot;
      logic                cfg_done;
      mrp_mode_t           mode;
      logic [3:0]          s_mode;
      logic [MRP_DIV_W-1:0] div;
      logic                own_clk;
      logic [1:0]          s_txc;
      logic [1:0]          s_rxc;
      logic [1:0]          s_ref;
      logic [11:0]         s_rx;
      logic                tlast;
      logic                rlast;
      logic [3:0]          txd;
      logic                tx_en;
      logic                tx_er;
      logic                tx_oe;
      logic                half_t;
      logic [1:0]          hi_t;
      logic                half_r;
      logic [1:0]          lo_r;
      logic                er_r;
      logic                take;
      logic                rv;
      logic [3:0]          rd;
      logic                re;
      logic                rf;
      logic                peer_oe;
      logic                osc_oe;
      logic                en_o;
      logic                en_oe;
   } mrp_mac_st_t;

   mrp_mac_st_t          q;
   mrp_mac_st_t          n;
   logic                 tclk;
   logic                 rclk;
   logic                 rmii;
   logic [MRP_DIV_W-1:0] half;
   logic [5:0]           rs;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      n = q;
      n.take = 1'b0;
      n.rv = 1'b0;
      n.rf = 1'b0;
      n.s_mode = {q.s_mode[1:0], mode_strap};
      n.s_txc = {q.s_txc[0], lnk.txc};
      n.s_rxc = {q.s_rxc[0], lnk.rxc};
      n.s_ref = {q.s_ref[0], lnk.ref_clk};
      n.s_rx = {q.s_rx[5:0], lnk.rx_dv, lnk.rx_er, lnk.rxd};
      rs = q.s_rx[11:6];
      if (!q.cfg_done)
      begin
         if (q.boot == MRP_CFG_WAIT)
         begin
            n.cfg_done = 1'b1;
            n.mode = mrp_mode_t'(q.s_mode[3:2]);
         end
         else
            n.boot = q.boot + 2'h1;
      end
      rmii = (q.mode == MRP_RMII) || (q.mode == MRP_RMII_EXT);
      half = rmii ? MRP_DIV_W'(HALF_RMII) : MRP_DIV_W'(HALF_MII);
      if (q.div >= half - MRP_DIV_W'(1))
      begin
         n.div = '0;
         n.own_clk = ~q.own_clk;
      end
      else
         n.div = q.div + MRP_DIV_W'(1);
      // pick the timing clock for each direction
      case (q.mode)
         MRP_MII:      begin tclk = q.s_txc[1]; rclk = q.s_rxc[1]; end
         MRP_RMII:     begin tclk = q.s_ref[1]; rclk = q.s_ref[1]; end
         MRP_RMII_EXT: begin tclk = q.own_clk;  rclk = q.own_clk;  end
         MRP_REV:      begin tclk = q.own_clk;  rclk = q.own_clk;  end
         default:      begin tclk = 1'b0;       rclk = 1'b0;       end
      endcase
      n.tlast = tclk;
      n.rlast = rclk;
      n.peer_oe = q.cfg_done && (q.mode == MRP_REV);
      n.osc_oe = q.cfg_done && (q.mode == MRP_RMII_EXT);
      n.en_o = phy_en;
      n.en_oe = ~phy_en_release;
      n.tx_oe = q.cfg_done;
      // transmit: launch on the falling edge of the timing clock
      if (q.cfg_done && !tclk && q.tlast)
      begin
         if (!rmii)
         begin
            n.tx_en = tx_valid;
            n.tx_er = tx_valid & tx_err;
            n.txd = tx_valid ? tx_data : MRP_NIB_IDLE;
            n.take = tx_valid;
         end
         else if (q.half_t)
         begin
            n.txd = {MRP_DIB_PAD, q.hi_t};
            n.half_t = 1'b0;
         end
         else
         begin
            n.tx_en = tx_valid;
            n.tx_er = 1'b0;
            n.txd = {MRP_DIB_PAD, tx_valid ? tx_data[1:0] : MRP_DIB_IDLE};
            n.hi_t = tx_data[3:2];
            n.half_t = tx_valid;
            n.take = tx_valid;
         end
      end
      // receive: sample on the rising edge of the timing clock
      if (q.cfg_done && rclk && !q.rlast)
      begin
         if (!rmii)
         begin
            n.rv = rs[5];
            n.rd = rs[3:0];
            n.re = rs[5] & rs[4];
            n.rf = !rs[5] && rs[4] && (rs[3:0] == MRP_NIB_FALSE);
         end
         else if (!rs[5])
            n.half_r = 1'b0;
         else if (!q.half_r)
         begin
            n.lo_r = rs[1:0];
            n.er_r = rs[4];
            n.half_r = 1'b1;
         end
         else
         begin
            n.rv = 1'b1;
            n.rd = {rs[1:0], q.lo_r};
            n.re = q.er_r | rs[4];
            n.half_r = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         q <= '0;
      else
         q <= n;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from state
   assign tx_take         = q.take;
   assign rx_valid        = q.rv;
   assign rx_data         = q.rd;
   assign rx_err          = q.re;
   assign rx_false        = q.rf;
   assign lnk.txd         = q.txd;
   assign lnk.tx_en_drv   = q.tx_en;
   assign lnk.tx_er_drv   = q.tx_er;
   assign lnk.tx_oe       = q.tx_oe;
   assign lnk.txc_mac     = q.own_clk;
   assign lnk.txc_mac_oe  = q.peer_oe;
   assign lnk.rxc_mac     = q.own_clk;
   assign lnk.rxc_mac_oe  = q.peer_oe;
   assign lnk.ref_clock_input = q.own_clk & q.osc_oe;
   assign lnk.en_mac      = q.en_o;
   assign lnk.en_mac_oe   = q.en_oe;
endmodule : mrp_mac_end

/* File: dv/mrp_link_sva.sv */
// Purpose: assertions on the pins between the two link ends
// Assumes: default pin clock half periods of 16 and 8 cycles
// Notes:   instantiated beside the link interface, no bind
`timescale 1ns/100ps
module mrp_link_sva
(
   input wire logic       clk_sys,         // system clock
   input wire logic       reset_n,         // async reset, low active
   input wire logic [3:0] txd,             // transmit data
   input wire logic       tx_en,           // resolved enable
   input wire logic       tx_er,           // resolved error
   input wire logic       tx_oe,           // controller drives tx
   input wire logic [3:0] rxd,             // receive data
   input wire logic       rx_dv,           // receive valid
   input wire logic       rx_er,           // receive error
   input wire logic       rx_oe,           // phy drives rx
   input wire logic       txc,             // resolved tx clock
   input wire logic       txc_phy_oe,      // phy drives txc
   input wire logic       txc_mac_oe,      // peer drives txc
   input wire logic       rxc_phy_oe,      // phy drives rxc
   input wire logic       rxc_mac_oe,      // peer drives rxc
   input wire logic       ref_clk,         // resolved reference
   input wire logic       ref_clk_phy_oe,  // phy drives reference
   input wire logic       test_clk_phy_oe, // phy drives enable pin
   input wire logic       en_mac_oe        // controller drives enable
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   // codes on the wire and quiet pins during boot
   chk_tx_no_rsvd: assert property (tx_er |-> tx_en)
      else $error("reserved transmit code on link");
   chk_rx_codes: assert property (rx_oe && !rx_dv && rx_er |->
      (rxd == 4'h0 || rxd == 4'hE)) else $error("reserved receive code");
   chk_boot_quiet: assert property ($rose(reset_n) |->
      (!rx_oe && !tx_oe)[*3]) else $error("pins driven during boot");
   // one driver per clock pin
   chk_txc_one_src: assert property (txc_phy_oe |-> !txc_mac_oe)
      else $error("two drivers on tx clock");
   chk_rxc_one_src: assert property (rxc_phy_oe |-> !rxc_mac_oe)
      else $error("two drivers on rx clock");
   chk_en_pin_share: assert property (test_clk_phy_oe |-> !en_mac_oe)
      else $error("two drivers on enable pin");
   // clock half periods and data standing times
   chk_txc_half: assert property ($changed(txc) && txc_phy_oe &&
      $past(txc_phy_oe) |=> ($stable(txc) || !txc_phy_oe)[*8])
      else $error("tx clock half period short");
   chk_ref_half: assert property ($changed(ref_clk) && ref_clk_phy_oe &&
      $past(ref_clk_phy_oe) |=> ($stable(ref_clk) || !ref_clk_phy_oe)[*7])
      else $error("reference half period short");
   chk_rxd_stands: assert property ($changed(rxd) && rx_oe &&
      $past(rx_oe) |=> ($stable(rxd) || !rx_oe)[*7])
      else $error("receive data changed early");
   chk_txd_stands: assert property ($changed(txd) && tx_oe &&
      $past(tx_oe) |=> ($stable(txd) || !tx_oe)[*7])
      else $error("transmit data changed early");
endmodule : mrp_link_sva

/* File: dv/tb_mii_rmii_phy_interface.sv */
// Purpose: both link ends back to back in every interface variant
// Assumes: default pin clock scaling of the design
// Notes:   line side of the phy end is driven by the bench
`timescale 1ns/100ps
module tb_mii_rmii_phy_interface;
   import mrp_pkg::*;
   logic       clk_sys, reset_n, battery_supply_ok, test_mode, phy_en;
   logic       phy_en_release, tx_valid, tx_err, line_rx_valid;
   logic       line_rx_err, line_false_carrier, tx_take, rx_valid;
   logic       rx_err, rx_false, line_rx_take, line_tx_valid;
   logic       line_tx_err, line_tx_rsvd, phy_enabled;
   logic [1:0] mode_strap;
   logic [3:0] tx_data, line_rx_data, rx_data, line_tx_data;
   int         n_fail, cmp_count;
   ////////////////////////////////////////////////////////////////////////
   // the two ends and the checker on the pins between them
   mrp_link_if lnk();
   mrp_phy_end mrp_phy_end_inst (.clk_sys, .reset_n, .battery_supply_ok,
      .test_mode, .mode_strap, .line_rx_valid, .line_rx_data, .line_rx_err,
      .line_false_carrier, .line_rx_take, .line_tx_valid, .line_tx_data,
      .line_tx_err, .line_tx_rsvd, .phy_enabled, .lnk(lnk));
   mrp_mac_end mrp_mac_end_inst (.clk_sys, .reset_n, .mode_strap, .phy_en,
      .phy_en_release, .tx_valid, .tx_data, .tx_err, .tx_take, .rx_valid,
      .rx_data, .rx_err, .rx_false, .lnk(lnk));
   mrp_link_sva mrp_link_sva_inst (.clk_sys, .reset_n, .txd(lnk.txd),
      .tx_en(lnk.tx_en), .tx_er(lnk.tx_er), .tx_oe(lnk.tx_oe),
      .rxd(lnk.rxd), .rx_dv(lnk.rx_dv), .rx_er(lnk.rx_er),
      .rx_oe(lnk.rx_oe), .txc(lnk.txc), .txc_phy_oe(lnk.txc_phy_oe),
      .txc_mac_oe(lnk.txc_mac_oe), .rxc_phy_oe(lnk.rxc_phy_oe),
      .rxc_mac_oe(lnk.rxc_mac_oe), .ref_clk(lnk.ref_clk),
      .ref_clk_phy_oe(lnk.ref_clk_phy_oe),
      .test_clk_phy_oe(lnk.test_clk_phy_oe), .en_mac_oe(lnk.en_mac_oe));
   ////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic chk(string nm, logic [3:0] ex, logic [3:0] got);
      cmp_count++;
      if (got !== ex)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic reset_to(logic [1:0] m);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      mode_strap <= m;
      repeat (3) @(posedge clk_sys);
      chk("tx_en", 4'h0, 4'(lnk.tx_en));
      reset_n <= 1'b1;
      repeat (150) @(posedge clk_sys);
   endtask : reset_to
   // one nibble from controller to line, held until taken
   task automatic xfer_tx(logic [3:0] d, logic e, logic ee);
      int i;
      @(posedge clk_sys);
      tx_valid <= 1'b1;
      tx_data <= d;
      tx_err <= e;
      @(posedge clk_sys);
      for (i = 0; i < 200 && tx_take !== 1'b1; i++) @(negedge clk_sys);
      @(posedge clk_sys);
      tx_valid <= 1'b0;
      for (i = 0; i < 200 && line_tx_valid !== 1'b1; i++) @(negedge clk_sys);
      chk("line_tx_data", d, line_tx_data);
      chk("line_tx_err", 4'(ee), 4'(line_tx_err));
   endtask : xfer_tx
   // one nibble or a false carrier from line to controller
   task automatic xfer_rx(logic [3:0] d, logic e, logic f);
      int i;
      @(posedge clk_sys);
      line_rx_valid <= !f;
      line_rx_data <= d;
      line_rx_err <= e;
      line_false_carrier <= f;
      repeat (2) @(negedge clk_sys);
      for (i = 0; i < 200 && line_rx_take !== 1'b1; i++) @(negedge clk_sys);
      @(posedge clk_sys);
      line_rx_valid <= 1'b0;
      line_false_carrier <= 1'b0;
      for (i = 0; i < 200 && rx_valid !== 1'b1 && rx_false !== 1'b1; i++)
         @(negedge clk_sys);
      chk("rx_false", 4'(f), 4'(rx_false));
      if (!f)
      begin
         chk("rx_data", d, rx_data);
         chk("rx_err", 4'(e), 4'(rx_err));
      end
   endtask : xfer_rx
   ////////////////////////////////////////////////////////////////////////
   // scenarios, one per interface variant or pin function
   task automatic t_mii();
      reset_to(MRP_MII);
      chk("rxc_phy_oe", 4'h1, 4'(lnk.rxc_phy_oe));
      xfer_tx(4'hA, 1'b0, 1'b0);
      xfer_tx(4'h5, 1'b1, 1'b1);
      xfer_rx(4'h3, 1'b0, 1'b0);
      xfer_rx(4'hC, 1'b1, 1'b0);
      xfer_rx(4'h0, 1'b0, 1'b1);
      @(posedge clk_sys);
      mode_strap <= MRP_RMII;
      xfer_tx(4'h9, 1'b0, 1'b0);
      chk("ref_clk_phy_oe", 4'h0, 4'(lnk.ref_clk_phy_oe));
   endtask : t_mii
   task automatic t_rmii();
      reset_to(MRP_RMII);
      chk("ref_clk_phy_oe", 4'h1, 4'(lnk.ref_clk_phy_oe));
      xfer_tx(4'h6, 1'b1, 1'b0);
      xfer_tx(4'hF, 1'b0, 1'b0);
      xfer_rx(4'h9, 1'b0, 1'b0);
      xfer_rx(4'h2, 1'b1, 1'b0);
   endtask : t_rmii
   task automatic t_ext();
      reset_to(MRP_RMII_EXT);
      chk("ref_clk_phy_oe", 4'h0, 4'(lnk.ref_clk_phy_oe));
      xfer_tx(4'h3, 1'b0, 1'b0);
      xfer_rx(4'hD, 1'b0, 1'b0);
   endtask : t_ext
   task automatic t_rev();
      reset_to(MRP_REV);
      chk("txc_phy_oe", 4'h0, 4'(lnk.txc_phy_oe));
      chk("rxc_phy_oe", 4'h0, 4'(lnk.rxc_phy_oe));
      chk("rxc_mac_oe", 4'h1, 4'(lnk.rxc_mac_oe));
      xfer_tx(4'h7, 1'b0, 1'b0);
      xfer_rx(4'hB, 1'b1, 1'b0);
   endtask : t_rev
   task automatic t_test_pin();
      test_mode <= 1'b1;
      phy_en_release <= 1'b1;
      phy_en <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk("test_clk_oe", 4'h1, 4'(lnk.test_clk_phy_oe));
      chk("phy_enabled", 4'h1, 4'(phy_enabled));
      test_mode <= 1'b0;
      phy_en_release <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk("phy_enabled", 4'h0, 4'(phy_enabled));
      phy_en <= 1'b1;
   endtask : t_test_pin
   task automatic t_battery();
      @(posedge clk_sys);
      battery_supply_ok <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("rx_oe", 4'h0, 4'(lnk.rx_oe));
      chk("phy_enabled", 4'h0, 4'(phy_enabled));
      battery_supply_ok <= 1'b1;
   endtask : t_battery
   task automatic give_verdict();
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////
   // clock, watchdog and main sequence
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial
   begin
      #800000;
      n_fail++;
      give_verdict();
   end
   initial
   begin
      {reset_n, test_mode, phy_en_release, tx_valid, tx_err, tx_data} = 9'h000;
      {line_rx_valid, line_rx_err, line_false_carrier, line_rx_data} = 7'h00;
      {battery_supply_ok, phy_en, mode_strap} = 4'hC;
      t_mii();
      t_rmii();
      t_ext();
      t_rev();
      t_battery();
      t_test_pin();
      give_verdict();
   end
endmodule : tb_mii_rmii_phy_interface
